//--- verilog/grs_pkg.sv
// package: constants and types of the global reset sequencer
package grs_pkg;
  localparam logic [7:0] CMD_GLOBAL_RESET = 8'h81;
  localparam logic [7:0] ACCESS_OPEN_A    = 8'h02;
  localparam logic [7:0] ACCESS_OPEN_B    = 8'h03;
  localparam logic [7:0] REG_CLEAR        = 8'h00;
  localparam int CLK_MHZ         = 20;
  localparam int INIT_LIMIT_US   = 500;
  localparam int INIT_LIMIT_CYC  = INIT_LIMIT_US * CLK_MHZ;
  localparam int CLEAR_DELAY_CYC = 2;
  localparam int INIT_WORK_CYC   = 64;
  typedef struct packed {
    logic       wr;
    logic [1:0] sel;
    logic [7:0] data;
  } grs_wr_type;
  localparam logic [1:0] SEL_ACCESS = 2'h0;
  localparam logic [1:0] SEL_CMD    = 2'h1;
  localparam logic [1:0] SEL_REV    = 2'h2;
endpackage : grs_pkg

//--- verilog/grs_global_reset_sequencer.sv
// global reset sequencer: command gating, restart and revision handshake
// ============================================================
// Behaviour
// - command writes are taken only while the access register holds 02h or 03h.
// - writing 81h to the command register starts a global reset equal to the reset pin.
// - a global reset clears interface registers, flushes the fifo and disables channels.
// - a global reset restarts the processor from its power-up location.
// - the active-low reset pin starts the full internal initialization.
// - the revision register is cleared early and written with the code last.
// - initialization finishes within 500 us; a timeout flag marks a failed start.
`timescale 1ns/1ps
module grs_global_reset_sequencer #(
  parameter logic [7:0] REVISION_CODE  = 8'h5A, // arbitrary value
  parameter int         INIT_LIMIT_CYC = grs_pkg::INIT_LIMIT_CYC,
  parameter int         INIT_WORK_CYC  = grs_pkg::INIT_WORK_CYC
) (
  input  wire logic               core_clk,
  input  wire logic               srst,
  input  wire logic               hw_reset_n,
  input  wire grs_pkg::grs_wr_type host_wr,
  output logic [7:0]              access_enable_reg,
  output logic [7:0]              reset_command_reg,
  output logic [7:0]              firmware_revision_reg,
  output logic                    iface_clear,
  output logic                    fifo_flush,
  output logic                    channel_disable,
  output logic                    cpu_restart,
  output logic                    init_busy,
  output logic                    init_timeout
);
  // ============================================================
  // pin synchroniser
  logic rst_meta, rst_sync;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rst_meta <= 1'b1;
      rst_sync <= 1'b1;
    end else begin
      rst_meta <= hw_reset_n;
      rst_sync <= rst_meta;
    end
  end

  function automatic logic access_open(input logic [7:0] v);
    access_open = (v == grs_pkg::ACCESS_OPEN_A) || (v == grs_pkg::ACCESS_OPEN_B);
  endfunction : access_open

  function automatic logic wr_hit(input grs_pkg::grs_wr_type w, input logic [1:0] s);
    wr_hit = w.wr && (w.sel == s);
  endfunction : wr_hit

  // ============================================================
  // sequencer
  typedef enum logic [1:0] {ST_RUN, ST_CLEAR, ST_INIT, ST_DONE} grs_state_type;
  grs_state_type state, next_state;
  logic [7:0]  next_access, next_cmd, next_rev;
  logic [31:0] cnt, next_cnt;
  logic [31:0] tmo, next_tmo;
  logic        next_timeout;
  logic        cmd_wr, start;

  always_comb begin
    cmd_wr = wr_hit(host_wr, grs_pkg::SEL_CMD)
             && access_open(access_enable_reg);
    start  = !rst_sync || (cmd_wr && host_wr.data == grs_pkg::CMD_GLOBAL_RESET);
    next_state   = state;
    next_access  = access_enable_reg;
    next_cmd     = reset_command_reg;
    next_rev     = firmware_revision_reg;
    next_cnt     = cnt;
    next_tmo     = tmo;
    next_timeout = init_timeout;
    if (wr_hit(host_wr, grs_pkg::SEL_ACCESS)) begin
      next_access = host_wr.data;
    end
    if (wr_hit(host_wr, grs_pkg::SEL_REV)) begin
      next_rev = host_wr.data;
    end
    if (cmd_wr && state == ST_RUN) begin
      next_cmd = host_wr.data;
    end
    case (state)
      ST_RUN: begin
        next_cmd = grs_pkg::REG_CLEAR;
        if (cmd_wr) next_cmd = host_wr.data;
      end
      ST_CLEAR: begin
        // interface registers dropped, restart at power-up location
        next_access = grs_pkg::REG_CLEAR;
        next_rev    = grs_pkg::REG_CLEAR;
        next_cmd    = grs_pkg::REG_CLEAR;
        next_cnt    = 32'h0;
        next_state  = ST_INIT;
      end
      ST_INIT: begin
        next_cmd = grs_pkg::REG_CLEAR;
        next_cnt = cnt + 32'h1;
        if (cnt >= 32'(INIT_WORK_CYC)) next_state = ST_DONE;
      end
      ST_DONE: begin
        next_rev   = REVISION_CODE;
        next_state = ST_RUN;
      end
      default: next_state = ST_RUN;
    endcase
    // the watchdog counts from start until the code lands
    if (state == ST_RUN) begin
      next_tmo = 32'h0;
    end else begin
      next_tmo = tmo + 32'h1;
      if (tmo >= 32'(INIT_LIMIT_CYC)) next_timeout = 1'b1;
    end
    if (start) begin
      next_state   = ST_CLEAR;
      next_tmo     = 32'h0;
      next_timeout = 1'b0;
      next_cmd     = grs_pkg::REG_CLEAR;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state                 <= ST_CLEAR;
      access_enable_reg     <= 8'h00;
      reset_command_reg     <= 8'h00;
      firmware_revision_reg <= 8'h00;
      cnt                   <= 32'h0;
      tmo                   <= 32'h0;
      init_timeout          <= 1'b0;
    end else begin
      state                 <= next_state;
      access_enable_reg     <= next_access;
      reset_command_reg     <= next_cmd;
      firmware_revision_reg <= next_rev;
      cnt                   <= next_cnt;
      tmo                   <= next_tmo;
      init_timeout          <= next_timeout;
    end
  end

  // ============================================================
  // flags
  // flush and disable held for the whole init so channels stay quiet
  always_comb begin
    iface_clear     = (state == ST_CLEAR);
    cpu_restart     = (state == ST_CLEAR);
    fifo_flush      = (state != ST_RUN);
    channel_disable = (state != ST_RUN);
    init_busy       = (state != ST_RUN);
  end

  // ============================================================
  // checks
  chk_cmd_gated: assert property (@(posedge core_clk) disable iff (srst)
    (host_wr.wr && host_wr.sel == grs_pkg::SEL_CMD && !access_open(access_enable_reg)
     && state == ST_RUN && rst_sync) |=> reset_command_reg == 8'h00)
    else $error("command taken while access closed");
  chk_start_reset: assert property (@(posedge core_clk) disable iff (srst)
    (cmd_wr && host_wr.data == grs_pkg::CMD_GLOBAL_RESET) |=> state == ST_CLEAR ##1 cpu_restart == 1'b0)
    else $error("reset command did not start sequence");
  chk_pin_reset: assert property (@(posedge core_clk) disable iff (srst)
    !rst_sync |=> init_busy)
    else $error("reset pin did not start init");
  sequence s_cleared;
    firmware_revision_reg == 8'h00 && access_enable_reg == 8'h00;
  endsequence
  chk_clear_early: assert property (@(posedge core_clk) disable iff (srst)
    (state == ST_CLEAR && !start) |=> s_cleared)
    else $error("revision not cleared early");
  chk_rev_last: assert property (@(posedge core_clk) disable iff (srst)
    (state == ST_DONE && !start) |=> firmware_revision_reg == REVISION_CODE && !init_busy)
    else $error("revision not written at end");
  chk_flush_held: assert property (@(posedge core_clk) disable iff (srst)
    start |=> (fifo_flush && channel_disable)[*3])
    else $error("fifo or channels live during init");
  chk_cmd_zero: assert property (@(posedge core_clk) disable iff (srst)
    (state == ST_RUN && !cmd_wr && !start) |=> reset_command_reg == 8'h00)
    else $error("command register not returned to zero");
  chk_timeout_flag: assert property (@(posedge core_clk) disable iff (srst)
    (state == ST_RUN) |=> $stable(init_timeout) || !init_timeout)
    else $error("timeout raised outside init");

  // restart steps: pulse on the first cycle, gone on the second
  sequence s_restart;
    cpu_restart && iface_clear && init_busy;
  endsequence
  sequence s_settled;
    !cpu_restart && !iface_clear && init_busy;
  endsequence
  chk_restart_step: assert property (@(posedge core_clk) disable iff (srst)
    start |=> s_restart)
    else $error("restart pulse missing after start");
  chk_restart_once: assert property (@(posedge core_clk) disable iff (srst)
    (start ##1 !start) |=> s_settled)
    else $error("restart pulse held too long");
  chk_pin_restart: assert property (@(posedge core_clk) disable iff (srst)
    $fell(rst_sync) |=> s_restart)
    else $error("reset pin did not restart the processor");

  // command and access registers
  chk_cmd_taken: assert property (@(posedge core_clk) disable iff (srst)
    (cmd_wr && state == ST_RUN && !start) |=> reset_command_reg == $past(host_wr.data))
    else $error("open command write not taken");
  chk_access_load: assert property (@(posedge core_clk) disable iff (srst)
    (wr_hit(host_wr, grs_pkg::SEL_ACCESS) && state != ST_CLEAR && !start)
    |=> access_enable_reg == $past(host_wr.data))
    else $error("access register write lost");
  chk_cmd_idle_init: assert property (@(posedge core_clk) disable iff (srst)
    (init_busy && !start) |=> reset_command_reg == 8'h00)
    else $error("command register not zero during init");

  // watchdog flag
  chk_timeout_set: assert property (@(posedge core_clk) disable iff (srst)
    (init_busy && !start && tmo == 32'(INIT_LIMIT_CYC)) |=> init_timeout)
    else $error("late init not flagged");
  chk_timeout_clear: assert property (@(posedge core_clk) disable iff (srst)
    start |=> !init_timeout)
    else $error("timeout flag kept over a new start");
endmodule : grs_global_reset_sequencer

//--- testbench/grs_testbench.sv
// testbench: drives the global reset sequencer and checks its restart handshake
`timescale 1ns/1ps
module testbench;
  // ==========================================
  // signals
  localparam logic [7:0] REV = 8'h5A; // arbitrary value
  logic                core_clk = 1'b0;
  logic                srst = 1'b1;
  logic                hw_reset_n = 1'b1;
  grs_pkg::grs_wr_type host_wr = '0;
  logic [7:0]          acc_q, cmd_q, rev_q;
  logic                iclr, flush, chdis, cpu_rs, busy, tmo;
  logic [7:0]          slow_rev;
  logic                slow_busy, slow_tmo;
  int                  mismatches = 0;
  int                  comparisons = 0;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
  always #25 core_clk = ~core_clk;
  // short counts keep the run small
  grs_global_reset_sequencer #(
    .REVISION_CODE(REV), .INIT_LIMIT_CYC(20), .INIT_WORK_CYC(4)) dut_u (
    .core_clk(core_clk), .srst(srst), .hw_reset_n(hw_reset_n), .host_wr(host_wr),
    .access_enable_reg(acc_q), .reset_command_reg(cmd_q), .firmware_revision_reg(rev_q),
    .iface_clear(iclr), .fifo_flush(flush), .channel_disable(chdis), .cpu_restart(cpu_rs),
    .init_busy(busy), .init_timeout(tmo));
  // init outlasts its limit here so the watchdog flag has to rise
  grs_global_reset_sequencer #(
    .REVISION_CODE(REV), .INIT_LIMIT_CYC(10), .INIT_WORK_CYC(30)) dut_slow_u (
    .core_clk(core_clk), .srst(srst), .hw_reset_n(hw_reset_n), .host_wr(host_wr),
    .access_enable_reg(), .reset_command_reg(), .firmware_revision_reg(slow_rev),
    .iface_clear(), .fifo_flush(), .channel_disable(), .cpu_restart(),
    .init_busy(slow_busy), .init_timeout(slow_tmo));
  // ==========================================
  // tasks
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  task wr(input logic [1:0] sel, input logic [7:0] d);
    @(posedge core_clk) host_wr <= '{wr: 1'b1, sel: sel, data: d};
    @(posedge core_clk) host_wr.wr <= 1'b0;
    #1;
  endtask : wr
  task wait_ready;
    int n;
    n = 0;
    // bounded so a stuck start ends the run
    while (busy !== 1'b0 && n < 100) begin
      @(posedge core_clk) #1;
      n++;
    end
    if (busy !== 1'b0) begin
      mismatches++;
      final_report();
    end
  endtask : wait_ready
  task wait_cmd_zero;
    int n;
    n = 0;
    while (cmd_q !== 8'h00 && n < 20) begin
      @(posedge core_clk) #1;
      n++;
    end
    if (cmd_q !== 8'h00) begin
      mismatches++;
      final_report();
    end
  endtask : wait_cmd_zero
  task t_timeout;
    int n;
    n = 0;
    while (slow_busy !== 1'b0 && n < 100) begin
      @(posedge core_clk) #1;
      n++;
    end
    if (slow_busy !== 1'b0) begin
      mismatches++;
      final_report();
    end
    `CHK(slow_tmo, 1'b1)
    `CHK(slow_rev, REV)
    $display("test timeout done");
  endtask : t_timeout
  task t_power;
    wait_ready();
    `CHK(rev_q, REV)
    `CHK(cmd_q, 8'h00)
    `CHK(tmo, 1'b0)
    $display("test power done");
  endtask : t_power
  task t_closed;
    wr(grs_pkg::SEL_ACCESS, 8'h00);
    wr(grs_pkg::SEL_CMD, 8'h81);
    `CHK(busy, 1'b0)
    `CHK(cmd_q, 8'h00)
    $display("test closed done");
  endtask : t_closed
  task t_cmd;
    wr(grs_pkg::SEL_ACCESS, 8'h03);
    `CHK(acc_q, 8'h03)
    wr(grs_pkg::SEL_CMD, 8'h05);
    `CHK(cmd_q, 8'h05)
    @(posedge core_clk) #1;
    `CHK(cmd_q, 8'h00)
    wr(grs_pkg::SEL_ACCESS, 8'h00);
    wr(grs_pkg::SEL_REV, 8'h00);
    `CHK(rev_q, 8'h00)
    wr(grs_pkg::SEL_ACCESS, 8'h02);
    wait_cmd_zero();
    wr(grs_pkg::SEL_CMD, 8'h81);
    `CHK(busy, 1'b1)
    `CHK(iclr, 1'b1)
    `CHK(cpu_rs, 1'b1)
    `CHK({flush, chdis}, 2'b11)
    @(posedge core_clk) #1;
    `CHK(acc_q, 8'h00)
    `CHK(rev_q, 8'h00)
    `CHK(cpu_rs, 1'b0)
    wait_ready();
    `CHK(rev_q, REV)
    `CHK(tmo, 1'b0)
    `CHK({cmd_q, flush, chdis}, 10'h000)
    $display("test command done");
  endtask : t_cmd
  task t_pin;
    @(posedge core_clk) hw_reset_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    hw_reset_n <= 1'b1;
    #1;
    `CHK(busy, 1'b1)
    `CHK(cpu_rs, 1'b1)
    `CHK(rev_q, 8'h00)
    wait_ready();
    `CHK(rev_q, REV)
    $display("test pin done");
  endtask : t_pin
  // ==========================================
  // sequence
  initial begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    t_power();
    t_timeout();
    t_closed();
    t_cmd();
    t_pin();
    final_report();
  end
endmodule : testbench
